// File: hdl/cdc_stage_input_config.sv
// Stage sequencer, per-stage input routing and result registers for the
// capacitance converter. Assumes the serial interface supplies a word
// register port and the analog converter answers each start with done.
`timescale 1ns/1ns
`default_nettype none
module cdc_stage_input_config #(
    parameter int unsigned MS_TICK_CYCLES = cdc_stage_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Register port from the serial interface
    input  wire logic [9:0]  regAddr,
    input  wire logic        regWrEn,
    input  wire logic [15:0] regWrData,
    input  wire logic        regRdEn,
    output logic [15:0]      regRdData,
    output logic             regRdValid,
    // Converter control
    output logic             convStart,
    output logic [2:0]       convStage,
    output logic [9:0]       convSamples,
    input  wire logic        convDone,
    input  wire logic [15:0] convData,
    // Switch matrix for the active stage
    output logic [7:0]       inputPosEn,
    output logic [7:0]       inputNegEn,
    output logic [7:0]       inputBiasEn,
    output logic [1:0]       stagePathMatch,
    output logic [15:0]      stageOffset,
    // Status
    output logic             seqBusy,
    output logic             pathMatchError
);
    import cdc_stage_pkg::*;

    typedef struct packed {
        logic [15:0]       pwrCtrl;
        logic [7:0][15:0]  rawResult;
        logic [7:0][15:0]  procResult;
        logic [7:0][15:0]  inputRoute;
        logic [7:0][1:0]   pathMatch;
        logic [7:0][15:0]  offset;
        logic [7:0][15:0]  sens;
        logic [7:0][15:0]  limit;
        seq_state_type     state;
        logic [2:0]        stage;
        logic [31:0]       msCnt;
        logic [9:0]        delayMs;
        logic              start;
        logic              badPath;
        logic [15:0]       rdData;
        logic              rdValid;
    } regs_type;

    regs_type    r_r;
    regs_type    r_nxt;
    logic [1:0]  mode;
    logic [3:0]  seqLenField;
    logic [2:0]  lastStage;
    logic [9:0]  decim;
    logic [9:0]  wakeMs;
    logic [2:0]  wordSel;
    logic [2:0]  cfgStage;
    logic [9:0]  rawIdx;
    logic [9:0]  procIdx;

    // Control field views
    assign mode        = r_r.pwrCtrl[MODE_LSB +: 2];
    assign seqLenField = r_r.pwrCtrl[SEQ_LEN_LSB +: 4];
    assign lastStage   = (seqLenField > 4'h7) ? 3'h7 : seqLenField[2:0];
    assign wordSel     = regAddr[2:0];
    assign cfgStage    = regAddr[5:3];
    assign rawIdx      = regAddr - RAW_RESULT_BASE;
    assign procIdx     = regAddr - PROC_RESULT_BASE;

    // Decimation and wake delay decode
    always_comb begin
        case (r_r.pwrCtrl[DECIM_LSB +: 2])
            2'h0:    decim = DECIM_256;
            2'h1:    decim = DECIM_128;
            default: decim = DECIM_64;
        endcase
        // 200 ms per step, code 0 is one step
        wakeMs = 10'(LP_DELAY_STEP_MS
                 * ({8'h00, r_r.pwrCtrl[LP_DELAY_LSB +: 2]} + 10'd1));
    end

    // Next-state logic: registers, sequencer, read data
    always_comb begin
        r_nxt         = r_r;
        r_nxt.start   = 1'b0;
        r_nxt.rdValid = regRdEn;

        // Register writes; result banks are read only
        if (regWrEn) begin
            if (regAddr == PWR_CTRL_ADDR) begin
                r_nxt.pwrCtrl = regWrData;
            end else if (regAddr >= STAGE_CFG_BASE
                         && regAddr < STAGE_CFG_END) begin
                if (wordSel == CFG_ROUTE) begin
                    r_nxt.inputRoute[cfgStage] = regWrData;
                end else if (wordSel == CFG_PATH) begin
                    r_nxt.pathMatch[cfgStage] = regWrData[1:0];
                end else if (wordSel == CFG_OFFSET) begin
                    r_nxt.offset[cfgStage] = regWrData;
                end else if (wordSel == CFG_SENS) begin
                    r_nxt.sens[cfgStage] = regWrData;
                end else if (wordSel == CFG_LIMIT) begin
                    r_nxt.limit[cfgStage] = regWrData;
                end
            end
        end

        // Register reads, unmapped addresses return zero
        r_nxt.rdData = 16'h0000;
        if (regAddr == PWR_CTRL_ADDR) begin
            r_nxt.rdData = r_r.pwrCtrl;
        end else if (regAddr == STATUS_ADDR) begin
            r_nxt.rdData = {11'h000, r_r.badPath, ~r_r.state[0],
                            r_r.stage};
        end else if (regAddr >= RAW_RESULT_BASE
                     && regAddr < RAW_RESULT_BASE + RESULT_SPAN) begin
            r_nxt.rdData = r_r.rawResult[rawIdx[2:0]];
        end else if (regAddr >= PROC_RESULT_BASE
                     && regAddr < PROC_RESULT_BASE + RESULT_SPAN) begin
            r_nxt.rdData = r_r.procResult[procIdx[2:0]];
        end else if (regAddr >= STAGE_CFG_BASE
                     && regAddr < STAGE_CFG_END) begin
            if (wordSel == CFG_ROUTE) begin
                r_nxt.rdData = r_r.inputRoute[cfgStage];
            end else if (wordSel == CFG_PATH) begin
                r_nxt.rdData = {14'h0000, r_r.pathMatch[cfgStage]};
            end else if (wordSel == CFG_OFFSET) begin
                r_nxt.rdData = r_r.offset[cfgStage];
            end else if (wordSel == CFG_SENS) begin
                r_nxt.rdData = r_r.sens[cfgStage];
            end else if (wordSel == CFG_LIMIT) begin
                r_nxt.rdData = r_r.limit[cfgStage];
            end
        end

        // Conversion sequencer
        case (r_r.state)
            ST_IDLE: begin
                if (mode == MODE_FULL || mode == MODE_LOW) begin
                    r_nxt.stage = 3'h0;
                    r_nxt.start = 1'b1;
                    r_nxt.state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (convDone) begin
                    r_nxt.rawResult[r_r.stage] = convData;
                    // Flag the reserved path code once its stage's conversion is done, held until the next done
                    r_nxt.badPath = (r_r.pathMatch[r_r.stage]
                                     == PATH_INVALID);
                    if (r_r.stage >= lastStage) begin
                        // Snapshot a coherent set for the host
                        r_nxt.procResult = r_r.rawResult;
                        r_nxt.procResult[r_r.stage] = convData;
                        r_nxt.stage = 3'h0;
                        if (mode == MODE_FULL) begin
                            r_nxt.start = 1'b1;
                        end else if (mode == MODE_LOW) begin
                            r_nxt.msCnt   = 32'h0;
                            r_nxt.delayMs = 10'h000;
                            r_nxt.state   = ST_WAKE;
                        end else begin
                            r_nxt.state = ST_IDLE;
                        end
                    end else begin
                        r_nxt.stage = r_r.stage + 3'h1;
                        r_nxt.start = 1'b1;
                    end
                end
            end
            ST_WAKE: begin
                if (mode != MODE_LOW) begin
                    r_nxt.state = ST_IDLE;
                end else if (r_r.msCnt == 32'(MS_TICK_CYCLES - 1)) begin
                    r_nxt.msCnt = 32'h0;
                    if (r_r.delayMs + 10'd1 >= wakeMs) begin
                        r_nxt.start = 1'b1;
                        r_nxt.state = ST_CONVERT;
                    end else begin
                        r_nxt.delayMs = r_r.delayMs + 10'd1;
                    end
                end else begin
                    r_nxt.msCnt = r_r.msCnt + 32'h1;
                end
            end
            default: begin
                r_nxt.state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            r_r            <= '0;
            r_r.pwrCtrl    <= PWR_CTRL_RESET;
            r_r.inputRoute <= {NUM_STAGES{ROUTE_RESET}};
            r_r.pathMatch  <= {NUM_STAGES{PATH_RESET}};
            r_r.offset     <= {NUM_STAGES{CFG_RESET}};
            r_r.sens       <= {NUM_STAGES{CFG_RESET}};
            r_r.limit      <= {NUM_STAGES{CFG_RESET}};
            r_r.state      <= ST_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Switch matrix for the stage being converted
    stage_route_decode i_stage_route_decode (
        .routeWord (r_r.inputRoute[r_r.stage]),
        .posEn     (inputPosEn),
        .negEn     (inputNegEn),
        .biasEn    (inputBiasEn)
    );

    // Outputs
    assign stagePathMatch = r_r.pathMatch[r_r.stage];
    assign stageOffset    = r_r.offset[r_r.stage];
    assign convSamples    = 10'(SAMPLES_PER_DEC) * decim;
    assign convStart      = r_r.start;
    assign convStage      = r_r.stage;
    assign regRdData      = r_r.rdData;
    assign regRdValid     = r_r.rdValid;
    assign seqBusy        = r_r.state[1];
    assign pathMatchError = r_r.badPath;
endmodule
`default_nettype wire

// File: hdl/cdc_stage_pkg.sv
// Shared constants and types for the converter stage control block.
// Assumes a 16-bit word register port and a single 125 MHz clock.
package cdc_stage_pkg;
    localparam int NUM_STAGES = 8;
    localparam int NUM_INPUTS = 8;

    // Register map (word addresses)
    localparam logic [9:0] PWR_CTRL_ADDR    = 10'h000;
    localparam logic [9:0] STATUS_ADDR      = 10'h001;
    localparam logic [9:0] RAW_RESULT_BASE  = 10'h00B;
    localparam logic [9:0] STAGE_CFG_BASE   = 10'h080;
    localparam logic [9:0] STAGE_CFG_END    = 10'h0C0;
    localparam logic [9:0] PROC_RESULT_BASE = 10'h0E0;
    localparam logic [9:0] RESULT_SPAN      = 10'h008;

    // Words inside one stage configuration block (stride of eight)
    localparam logic [2:0] CFG_ROUTE  = 3'h0;
    localparam logic [2:0] CFG_PATH   = 3'h1;
    localparam logic [2:0] CFG_OFFSET = 3'h2;
    localparam logic [2:0] CFG_SENS   = 3'h3;
    localparam logic [2:0] CFG_LIMIT  = 3'h4;

    // Power control field positions
    localparam int MODE_LSB     = 0;
    localparam int LP_DELAY_LSB = 2;
    localparam int SEQ_LEN_LSB  = 4;
    localparam int DECIM_LSB    = 8;

    // Reset values
    localparam logic [15:0] PWR_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ROUTE_RESET    = 16'hFFFF;
    localparam logic [1:0]  PATH_RESET     = 2'h3;
    localparam logic [15:0] CFG_RESET      = 16'h0000;

    // Power modes
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_LOW  = 2'h2;

    // Input routing codes
    localparam logic [1:0] ROUTE_FLOAT = 2'h0;
    localparam logic [1:0] ROUTE_NEG   = 2'h1;
    localparam logic [1:0] ROUTE_POS   = 2'h2;
    localparam logic [1:0] ROUTE_BIAS  = 2'h3;

    // Path matching codes
    localparam logic [1:0] PATH_INVALID = 2'h0;
    localparam logic [1:0] PATH_SE_POS  = 2'h1;
    localparam logic [1:0] PATH_SE_NEG  = 2'h2;
    localparam logic [1:0] PATH_DIFF    = 2'h3;

    // Decimation and averaging
    localparam logic [9:0] DECIM_256        = 10'h100;
    localparam logic [9:0] DECIM_128        = 10'h080;
    localparam logic [9:0] DECIM_64         = 10'h040;
    localparam int         SAMPLES_PER_DEC  = 3;

    // Timing
    localparam int          CLK_FREQ_HZ      = 125_000_000;
    localparam int          MS_PER_SEC       = 1000;
    localparam int          MS_CYCLES        = CLK_FREQ_HZ / MS_PER_SEC;
    localparam logic [9:0]  LP_DELAY_STEP_MS = 10'd200;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_CONVERT = 3'b010,
        ST_WAKE    = 3'b100
    } seq_state_type;
endpackage

// File: hdl/stage_route_decode.sv
// Decodes one stage's 2-bit per-input routing codes into switch enables.
// Assumes the route word packs input n at bits [2n+1:2n].
`timescale 1ns/1ns
`default_nettype none
module stage_route_decode (
    // Packed routing codes
    input  wire logic [15:0] routeWord,
    // Switch matrix enables
    output logic [7:0]       posEn,
    output logic [7:0]       negEn,
    output logic [7:0]       biasEn
);
    import cdc_stage_pkg::*;

    // One decoder slice per sense input; code 00 leaves it floating
    genvar i;
    generate
        for (i = 0; i < NUM_INPUTS; i++) begin : g_in
            assign posEn[i]  = (routeWord[2*i+1:2*i] == ROUTE_POS);
            assign negEn[i]  = (routeWord[2*i+1:2*i] == ROUTE_NEG);
            assign biasEn[i] = (routeWord[2*i+1:2*i] == ROUTE_BIAS);
        end
    endgenerate
endmodule
`default_nettype wire

// File: testbench/cdc_stage_checker.sv
// Port level assertions for the converter stage control block.
// Assumes a single clock and synchronous active high reset.
`timescale 1ns/1ns
`default_nettype none
module cdc_stage_checker (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        regRdEn,
    input  wire logic        regRdValid,
    input  wire logic        convStart,
    input  wire logic [2:0]  convStage,
    input  wire logic [9:0]  convSamples,
    input  wire logic        convDone,
    input  wire logic [7:0]  inputPosEn,
    input  wire logic [7:0]  inputNegEn,
    input  wire logic [7:0]  inputBiasEn,
    input  wire logic [1:0]  stagePathMatch,
    input  wire logic        seqBusy,
    input  wire logic        pathMatchError
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_RD_VALID: assert property (regRdEn |=> regRdValid)
        else $error("read valid missing");
    AST_RD_QUIET: assert property (!regRdEn |=> !regRdValid)
        else $error("read valid without read");
    AST_SAMPLES: assert property (
        convSamples inside {10'h300, 10'h180, 10'h0C0})
        else $error("sample count wrong");
    AST_ROUTE_EXCL: assert property (
        ((inputPosEn & inputNegEn) | (inputPosEn & inputBiasEn) |
        (inputNegEn & inputBiasEn)) == 8'h00)
        else $error("input routed twice");
    AST_START_PULSE: assert property (convStart |=> !convStart)
        else $error("start longer than one cycle");
    AST_STAGE_HOLD: assert property (
        seqBusy && !convDone |=> $stable(convStage))
        else $error("stage moved during conversion");
    AST_PATH_ERR: assert property (
        convDone && seqBusy |=>
        pathMatchError == ($past(stagePathMatch) == 2'h0))
        else $error("path error flag wrong");
    AST_FIRST_STAGE: assert property (
        convStart && !$past(seqBusy) |-> convStage == 3'h0)
        else $error("sequence not started at stage zero");
endmodule
`default_nettype wire
bind cdc_stage_input_config cdc_stage_checker i_cdc_stage_checker (.clk,
    .reset, .regRdEn, .regRdValid, .convStart, .convStage, .convSamples,
    .convDone, .inputPosEn, .inputNegEn, .inputBiasEn, .stagePathMatch,
    .seqBusy, .pathMatchError);

// File: testbench/cdc_stage_input_config_bench.sv
// Self-checking bench for the converter stage control block.
// Assumes the converter model answers every start within a few cycles.
`timescale 1ns/1ns
`default_nettype none
module cdc_stage_input_config_bench;
    import cdc_stage_pkg::*;
    logic clk = 1'b0, reset = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic [9:0]  regAddr = 10'h000;
    logic [15:0] regWrData = 16'h0000, regRdData, convData, stageOffset;
    logic regRdValid, convStart, convDone, seqBusy, pathMatchError;
    logic [2:0]  convStage;
    logic [9:0]  convSamples;
    logic [7:0]  inputPosEn, inputNegEn, inputBiasEn, p, n, f;
    logic [1:0]  stagePathMatch;
    logic [15:0] v, w;
    int errors = 0, cmp_count = 0, k;
    always #4 clk = ~clk;
    cdc_stage_input_config #(.MS_TICK_CYCLES(4)) i_cdc_stage_input_config (
        .clk, .reset, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
        .regRdValid, .convStart, .convStage, .convSamples, .convDone,
        .convData, .inputPosEn, .inputNegEn, .inputBiasEn, .stagePathMatch,
        .stageOffset, .seqBusy, .pathMatchError);
    conv_model i_conv_model (.clk, .convStart, .convStage, .convDone,
        .convData);
    // Compare and count
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(negedge clk);
        regWrEn   = 1'b1;
        regAddr   = a;
        regWrData = d;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        @(negedge clk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRdEn = 1'b0;
        chk({15'h0, regRdValid}, 16'h0001);
        d = regRdData;
    endtask
    // Waits for the next start pulse, bounded
    task automatic wait_start();
        int i;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (convStart !== 1'b1 && i < 5000);
        if (i >= 5000) chk(16'hDEAD, 16'h0000);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Tests need about 25000 cycles; allow 50000 before giving up
    initial begin
        #400_000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        // Reset values and an unmapped read
        chk({8'h00, inputBiasEn}, 16'h00FF);
        rd(STAGE_CFG_BASE, v);
        chk(v, ROUTE_RESET);
        rd(STAGE_CFG_BASE + 10'h1, v);
        chk(v, 16'h0003);
        rd(PWR_CTRL_ADDR, v);
        chk(v, PWR_CTRL_RESET);
        rd(10'h3FF, v);
        chk(v, 16'h0000);
        $display("test reset done");
        // Distinct routing and offset per stage, invalid path on stage 5 only, eight stages
        for (int s = 0; s < 8; s++) begin
            for (int i = 0; i < 8; i++)
                w[2*i +: 2] = (i == s) ? ROUTE_POS : (i == (s+1)%8) ?
                    ROUTE_NEG : (i == (s+2)%8) ? ROUTE_FLOAT : ROUTE_BIAS;
            wr(STAGE_CFG_BASE + 10'(8*s), w);
            wr(STAGE_CFG_BASE + 10'(8*s+1), (s == 5) ? PATH_INVALID :
                PATH_DIFF);
            wr(STAGE_CFG_BASE + 10'(8*s+2), 16'h1000 + 16'(s));
        end
        wr(PWR_CTRL_ADDR, 16'h0070);
        for (k = 0; k < 2; k++) do wait_start(); while (convStage !== 3'h0);
        for (int s = 0; s < 8; s++) begin
            if (s != 0) wait_start();
            p = 8'h01 << s;
            n = 8'h01 << ((s+1)%8);
            f = 8'h01 << ((s+2)%8);
            chk({13'h0, convStage}, 16'(s));
            chk({15'h0, seqBusy}, 16'h0001);
            chk({inputPosEn, inputNegEn}, {p, n});
            chk({8'h00, inputBiasEn}, {8'h00, ~(p | n | f)});
            chk({14'h0, stagePathMatch}, (s == 5) ? 16'h0 : 16'h3);
            chk(stageOffset, 16'h1000 + 16'(s));
            chk({15'h0, pathMatchError}, (s == 6) ? 16'h1 : 16'h0);
        end
        wait_start();
        chk({13'h0, convStage}, 16'h0000);
        $display("test routing done");
        // Raw and processed results; raw words refuse writes
        wr(RAW_RESULT_BASE, 16'h0000);
        for (int s = 0; s < 8; s++) begin
            rd(RAW_RESULT_BASE + 10'(s), v);
            chk(v, 16'h8000 + 16'h0123 * 16'(s));
            rd(PROC_RESULT_BASE + 10'(s), v);
            chk(v, 16'h8000 + 16'h0123 * 16'(s));
        end
        $display("test results done");
        // Single-ended stages carry their matching path code
        wr(STAGE_CFG_BASE, 16'hFFFE);
        wr(STAGE_CFG_BASE + 10'h1, 16'(PATH_SE_POS));
        wr(STAGE_CFG_BASE + 10'h8, 16'hFFF7);
        wr(STAGE_CFG_BASE + 10'h9, 16'(PATH_SE_NEG));
        rd(STAGE_CFG_BASE + 10'h1, v);
        chk(v, 16'h0001);
        rd(STAGE_CFG_BASE + 10'h9, v);
        chk(v, 16'h0002);
        $display("test single ended done");
        // Decimation codes
        for (int d = 0; d < 4; d++) begin
            wr(PWR_CTRL_ADDR, 16'h0070 | 16'(d << DECIM_LSB));
            chk({6'h0, convSamples}, (d == 0) ? 16'h0300 : (d == 1) ?
                16'h0180 : 16'h00C0);
        end
        $display("test decimation done");
        // Low power wake delay for each code
        for (int c = 0; c < 4; c++) begin
            wr(PWR_CTRL_ADDR, 16'(MODE_LOW) | 16'(c << LP_DELAY_LSB));
            wait_start();
            wait_start();
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (!convDone && k < 50);
            chk({15'h0, seqBusy}, 16'h0000);
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (convStart !== 1'b1 && k < 5000);
            chk({15'h0, (k >= 800*(c+1)) && (k <= 800*(c+1) + 4)},
                16'h0001);
            chk({13'h0, convStage}, 16'h0000);
            chk({inputPosEn, inputNegEn}, 16'h0100);
            rd(STATUS_ADDR, v);
            chk(v, 16'h0008);
        end
        $display("test low power done");
        end_of_test();
    end
endmodule
`default_nettype wire

// File: testbench/conv_model.sv
// Behavioural converter answering each start with done and a result.
// Assumes convStart and convStage are registered on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module conv_model (
    // Clock
    input  wire logic        clk,
    // From the block
    input  wire logic        convStart,
    input  wire logic [2:0]  convStage,
    // Back to the block
    output logic             convDone,
    output logic [15:0]      convData
);
    logic [2:0] stg = 3'h0;
    logic [3:0] cnt = 4'h0;
    logic       slow = 1'b0;
    logic        doneQ = 1'b0;
    logic [15:0] dataQ = 16'h0000;
    // Single driver per output, known from time zero
    assign convDone = doneQ;
    assign convData = dataQ;
    // Alternates a prompt and a slow answer; data toggles when not valid
    always @(negedge clk) begin
        doneQ <= 1'b0;
        dataQ <= ~dataQ;
        if (cnt == 4'h1) begin
            doneQ <= 1'b1;
            dataQ <= 16'h8000 + 16'h0123 * stg;
        end
        if (cnt != 4'h0) cnt <= cnt - 4'h1;
        if (convStart) begin
            stg  <= convStage;
            cnt  <= slow ? 4'h6 : 4'h3;
            slow <= ~slow;
        end
    end
endmodule
`default_nettype wire
